// [logic/cfgap_top.sv]
// Notes on behaviour
// - strap sampled on reset falling edge, held
// - strap 0 decodes 3F0H, 1 decodes 370H
// - data port at index port plus one
// - index/data ports act only in config
// - index readable only in config state
// - power-up leaves device in run state
// - key 55H enters config state
// - index 00-2FH selects data port target
// - config access held until exit key
// - key AAH leaves config state
// - function blocks keep running in config
// - registers default at power-up, not reset
`timescale 1ns/1ps
module cfgap_top
    import cfgap_pkg::*;
(
    input  wire logic                  I_CLOCK,
    input  wire logic                  I_RST,
    input  wire logic                  I_POR,
    input  wire logic                  I_STRAP,
    input  wire logic [ADDR_W-1:0]     I_ADDR,
    input  wire logic                  I_IOR,
    input  wire logic                  I_IOW,
    input  wire logic [7:0]            I_DATA,
    output logic      [7:0]            O_DATA,
    output logic                       O_DATA_OE,
    output logic                       O_CONFIG_ACTIVE,
    output logic                       O_BASE_SELECT,
    output logic      [NUM_REGS*8-1:0] O_CONFIG_REGS
);
    // synchronised copies of the host bus pins
    logic [ADDR_W-1:0] addr_s;
    logic              ior_s;
    logic              iow_s;
    logic [7:0]        data_s;
    logic              strap_s;

    // strobe edge detectors
    logic              ior_d_reg;
    logic              ior_d_next;
    logic              iow_d_reg;
    logic              iow_d_next;
    logic              rd_pulse;
    logic              wr_pulse;

    // hardware reset release and latched strap
    logic              rst_d_reg;
    logic              rst_d_next;
    logic              rst_fall;
    logic              strap_reg;
    logic              strap_next;

    // access state and index selection
    cfgap_state_t      state_reg;
    cfgap_state_t      state_next;
    logic [7:0]        index_reg;
    logic [7:0]        index_next;

    // read return path
    logic [7:0]        rd_value;
    logic [7:0]        rdata_reg;
    logic [7:0]        rdata_next;
    logic              oe_reg;
    logic              oe_next;

    // port decode and qualified accesses
    logic [ADDR_W-1:0] base_addr;
    logic [ADDR_W-1:0] data_addr;
    logic              hit_base;
    logic              hit_data;
    logic              in_range;
    logic              cfg_on;
    logic              key_wr;
    logic              exit_wr;
    logic              index_wr;
    logic              data_wr;
    logic              index_rd;
    logic              data_rd;
    logic              reg_we;
    logic [7:0]        reg_rdata;

    // host bus pins pass two flops before use; address and data share the
    // strobes' delay so they line up with the strobe edge
    cfgap_sync #(
        .W (ADDR_W + 10)
    ) u_sync (
        .i_clk   (I_CLOCK),
        .i_async ({I_ADDR, I_IOR, I_IOW, I_DATA}),
        .o_sync  ({addr_s, ior_s, iow_s, data_s})
    );

    // board strap level, synchronised on its own
    cfgap_sync #(
        .W (1)
    ) u_strap_sync (
        .i_clk   (I_CLOCK),
        .i_async (I_STRAP),
        .o_sync  (strap_s)
    );

    // index check shared by the read and write paths
    function automatic logic index_ok(input logic [7:0] idx);
        return idx <= LAST_INDEX;
    endfunction

    // rising edge of a sampled level, used by both strobes
    function automatic logic rising(input logic now_v, input logic was_v);
        return now_v && !was_v;
    endfunction

    // strobe edges: one action per strobe, however long the host holds it
    always_comb begin
        ior_d_next = ior_s;
        iow_d_next = iow_s;
        rd_pulse   = rising(ior_s, ior_d_reg);
        wr_pulse   = rising(iow_s, iow_d_reg);
    end

    // cleared to the idle level of the strobes, so no false edge after power-up
    always_ff @(posedge I_CLOCK) begin
        if (I_POR) begin
            ior_d_reg <= 1'b0;
            iow_d_reg <= 1'b0;
        end else begin
            ior_d_reg <= ior_d_next;
            iow_d_reg <= iow_d_next;
        end
    end

    // hardware reset release; followed through power-up as well, so that a
    // release together with power-up still latches the strap
    always_comb begin
        rst_d_next = I_RST;
        rst_fall   = rst_d_reg && !I_RST;
    end

    // previous level of hardware reset, never cleared
    always_ff @(posedge I_CLOCK) begin
        rst_d_reg <= rst_d_next;
    end

    // strap taken on the falling edge of hardware reset, held until the next
    always_comb begin
        strap_next = strap_reg;
        if (rst_fall) begin
            strap_next = strap_s;
        end
    end

    // only power-up clears it; hardware reset itself must not move the base
    always_ff @(posedge I_CLOCK) begin
        if (I_POR) begin
            strap_reg <= 1'b0;
        end else begin
            strap_reg <= strap_next;
        end
    end

    // port decode against the latched base; the data port sits one above
    // the shared config/index address
    always_comb begin
        base_addr = strap_reg ? BASE_HIGH_ADDR : BASE_LOW_ADDR;
        data_addr = ADDR_W'(base_addr + DATA_PORT_OFS);
        hit_base  = (addr_s == base_addr);
        hit_data  = (addr_s == data_addr);
        in_range  = index_ok(index_reg);
    end

    // config state flag shared by decode, reads and the output
    always_comb begin
        cfg_on = (state_reg == CFGAP_CONFIG);
    end

    // qualified writes; the shared config/index address needs the state to
    // tell a key from an index
    always_comb begin
        key_wr   = wr_pulse && hit_base && !cfg_on && (data_s == ENTRY_KEY);
        exit_wr  = wr_pulse && hit_base && cfg_on && (data_s == EXIT_KEY);
        index_wr = wr_pulse && hit_base && cfg_on && (data_s != EXIT_KEY);
        data_wr  = wr_pulse && hit_data && cfg_on;
    end

    // qualified reads; outside config neither port answers
    always_comb begin
        index_rd = rd_pulse && hit_base && cfg_on;
        data_rd  = rd_pulse && hit_data && cfg_on;
    end

    // access state: run until the entry key, config until the exit key;
    // a hardware reset leaves it where it is
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CFGAP_RUN: begin
                // any other byte to the config port is ignored here
                if (key_wr) begin
                    state_next = CFGAP_CONFIG;
                end
            end
            CFGAP_CONFIG: begin
                // index and data traffic never leaves this state
                if (exit_wr) begin
                    state_next = CFGAP_RUN;
                end
            end
            default: begin
                state_next = CFGAP_RUN;
            end
        endcase
    end

    // cleared on power-up only; the function blocks are never held off,
    // whatever state the access logic is in
    always_ff @(posedge I_CLOCK) begin
        if (I_POR) begin
            state_reg <= CFGAP_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // index selection register, loaded by non-exit bytes to the port
    always_comb begin
        index_next = index_reg;
        if (index_wr) begin
            index_next = data_s;
        end
    end

    // index survives hardware reset, like the registers it points at
    always_ff @(posedge I_CLOCK) begin
        if (I_POR) begin
            index_reg <= INDEX_RESET;
        end else begin
            index_reg <= index_next;
        end
    end

    // out-of-range data writes are dropped rather than aliased
    always_comb begin
        reg_we = data_wr && in_range;
    end

    // configuration register storage
    cfgap_regfile u_regs (
        .i_clk   (I_CLOCK),
        .i_por   (I_POR),
        .i_we    (reg_we),
        .i_index (index_reg),
        .i_wdata (data_s),
        .o_rdata (reg_rdata),
        .o_flat  (O_CONFIG_REGS)
    );

    // value a read would return; an invalid index reads as zero
    always_comb begin
        rd_value = 8'h00;
        if (hit_base) begin
            rd_value = index_reg;
        end else if (in_range) begin
            rd_value = reg_rdata;
        end
    end

    // read data and drive enable while read strobe held
    always_comb begin
        rdata_next = rdata_reg;
        oe_next    = oe_reg;
        if (!ior_s) begin
            oe_next = 1'b0;
        end else if (index_rd || data_rd) begin
            rdata_next = rd_value;
            oe_next    = 1'b1;
        end
    end

    // read data held in flops so the bus sees a steady byte
    always_ff @(posedge I_CLOCK) begin
        if (I_POR) begin
            rdata_reg <= 8'h00;
            oe_reg    <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            oe_reg    <= oe_next;
        end
    end

    // outputs straight from registers
    assign O_DATA          = rdata_reg;
    assign O_DATA_OE       = oe_reg;
    assign O_CONFIG_ACTIVE = cfg_on;
    assign O_BASE_SELECT   = strap_reg;
endmodule

// [common/cfgap_pkg.sv]
package cfgap_pkg;
    // host i/o address width and port addresses
    localparam int          ADDR_W          = 10;
    localparam logic [9:0]  BASE_LOW_ADDR   = 10'h3F0;
    localparam logic [9:0]  BASE_HIGH_ADDR  = 10'h370;
    localparam logic [9:0]  DATA_PORT_OFS   = 10'h001;
    // access keys
    localparam logic [7:0]  ENTRY_KEY       = 8'h55;
    localparam logic [7:0]  EXIT_KEY        = 8'hAA;
    // register file size
    localparam int          NUM_REGS        = 48;
    localparam logic [7:0]  LAST_INDEX      = 8'h2F;
    localparam logic [7:0]  INDEX_RESET     = 8'h00;
    // identification register contents
    localparam logic [7:0]  DEVICE_ID_VAL   = 8'h5C; // arbitrary value
    localparam logic [7:0]  REVISION_VAL    = 8'h00; // arbitrary value
    // power-up defaults of the first registers, rest zero
    localparam logic [7:0]  REG_DEFAULT [NUM_REGS] = '{
        8'h28, 8'h9C, 8'h88, 8'h70, 8'h00, 8'h00, 8'hFF, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h02, DEVICE_ID_VAL, REVISION_VAL, 8'h00,
        8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00,
        8'h3C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // access state
    typedef enum logic [0:0] {
        CFGAP_RUN    = 1'b0,
        CFGAP_CONFIG = 1'b1
    } cfgap_state_t;
endpackage

// [logic/cfgap_sync.sv]
`timescale 1ns/1ps
module cfgap_sync
    import cfgap_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // two-stage synchroniser, no reset
    always_ff @(posedge i_clk) begin
        meta_reg <= i_async;
        sync_reg <= meta_reg;
    end
    assign o_sync = sync_reg;
endmodule

// [logic/cfgap_regfile.sv]
`timescale 1ns/1ps
module cfgap_regfile
    import cfgap_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_por,
    input  wire logic       i_we,
    input  wire logic [7:0] i_index,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata,
    output logic      [NUM_REGS*8-1:0] o_flat
);
    logic [7:0] mem_reg  [NUM_REGS];
    logic [7:0] mem_next [NUM_REGS];

    // next values: write at index, defaults on power-up only
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            mem_next[i] = mem_reg[i];
            if (i_por) begin
                mem_next[i] = REG_DEFAULT[i];
            end else if (i_we && (i_index == 8'(i))) begin
                mem_next[i] = i_wdata;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        mem_reg <= mem_next;
    end

    // read mux, out-of-range reads zero
    always_comb begin
        o_rdata = 8'h00;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (i_index == 8'(i)) begin
                o_rdata = mem_reg[i];
            end
            o_flat[i*8 +: 8] = mem_reg[i];
        end
    end
endmodule

// [test/cfgap_chk.sv]
`timescale 1ns/1ps
module cfgap_chk
    import cfgap_pkg::*;
(
    input wire logic                  I_CLOCK,
    input wire logic                  I_RST,
    input wire logic                  I_POR,
    input wire logic                  I_STRAP,
    input wire logic [ADDR_W-1:0]     I_ADDR,
    input wire logic                  I_IOR,
    input wire logic                  I_IOW,
    input wire logic [7:0]            I_DATA,
    input wire logic [7:0]            O_DATA,
    input wire logic                  O_DATA_OE,
    input wire logic                  O_CONFIG_ACTIVE,
    input wire logic                  O_BASE_SELECT,
    input wire logic [NUM_REGS*8-1:0] O_CONFIG_REGS
);
    // port base the host must hit
    logic [ADDR_W-1:0] base;
    assign base = O_BASE_SELECT ? BASE_HIGH_ADDR : BASE_LOW_ADDR;
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_POR);
    property p_enter;
        $rose(I_IOW) && I_ADDR == base && I_DATA == ENTRY_KEY |-> ##[1:4] O_CONFIG_ACTIVE;
    endproperty
    a_enter: assert property (p_enter) else $error("entry key ignored");
    property p_exit;
        $rose(I_IOW) && I_ADDR == base && I_DATA == EXIT_KEY && O_CONFIG_ACTIVE
            |-> ##[1:4] !O_CONFIG_ACTIVE;
    endproperty
    a_exit: assert property (p_exit) else $error("exit key ignored");
    property p_other;
        $rose(I_IOW) && I_ADDR == base && I_DATA != ENTRY_KEY && !O_CONFIG_ACTIVE
            |=> !O_CONFIG_ACTIVE [*4];
    endproperty
    a_other: assert property (p_other) else $error("wrong key entered config");
    property p_oe_cfg;
        O_DATA_OE |-> O_CONFIG_ACTIVE;
    endproperty
    a_oe_cfg: assert property (p_oe_cfg) else $error("bus driven in run state");
    property p_read;
        $rose(I_IOR) && O_CONFIG_ACTIVE && I_ADDR[9:1] == base[9:1] |-> ##[2:5] O_DATA_OE;
    endproperty
    a_read: assert property (p_read) else $error("config read not answered");
    property p_oe_drop;
        $fell(I_IOR) |-> ##[2:4] !O_DATA_OE;
    endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("bus drive not released");
    property p_strap;
        $fell(I_RST) |-> ##[1:4] O_BASE_SELECT == I_STRAP;
    endproperty
    a_strap: assert property (p_strap) else $error("strap not latched");
    property p_strap_hold;
        !I_RST [*6] |=> $stable(O_BASE_SELECT);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("base select moved");
    property p_regs;
        !O_CONFIG_ACTIVE && !$past(O_CONFIG_ACTIVE) |-> $stable(O_CONFIG_REGS);
    endproperty
    a_regs: assert property (p_regs) else $error("registers changed in run");
    c_enter: cover property ($rose(O_CONFIG_ACTIVE));
    c_read: cover property ($rose(O_DATA_OE));
    c_high: cover property ($rose(O_BASE_SELECT));
endmodule
bind cfgap_top cfgap_chk cfgap_chk_inst (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_POR(I_POR),
    .I_STRAP(I_STRAP), .I_ADDR(I_ADDR), .I_IOR(I_IOR), .I_IOW(I_IOW), .I_DATA(I_DATA),
    .O_DATA(O_DATA), .O_DATA_OE(O_DATA_OE), .O_CONFIG_ACTIVE(O_CONFIG_ACTIVE),
    .O_BASE_SELECT(O_BASE_SELECT), .O_CONFIG_REGS(O_CONFIG_REGS));

// [test/cfgap_host.sv]
`timescale 1ns/1ps
module cfgap_host
    import cfgap_pkg::*;
(
    input  wire logic              i_clk,
    output logic      [ADDR_W-1:0] o_addr,
    output logic                   o_ior,
    output logic                   o_iow,
    output logic      [7:0]        o_data
);
    // idle bus at time zero
    initial begin
        o_addr = '0;
        o_data = '0;
        o_ior  = 1'h0;
        o_iow  = 1'h0;
    end
    // one i/o cycle; released lines flip so stale values never match
    task automatic io(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_data = d;
        o_iow  = wr;
        o_ior  = !wr;
        repeat (wr ? 3 : 6) @(posedge i_clk);
        #1;
        o_iow  = 1'h0;
        o_ior  = 1'h0;
        o_addr = ~a;
        o_data = ~d;
        repeat (5) @(posedge i_clk);
        #2;
    endtask
endmodule

// [test/config_access_port_logic_tb_top.sv]
`timescale 1ns/1ps
module config_access_port_logic_tb_top import cfgap_pkg::*;;
    logic                  clk = 0, rst = 1, por = 1, strap = 0, ior, iow, oe, act, bsel, oe_q = 0;
    logic [ADDR_W-1:0]     addr;
    logic [7:0]            wdata, rdata, idx, d;
    logic [NUM_REGS*8-1:0] regs, flat;
    logic [7:0]            exp_q [$];
    logic [7:0]            model [NUM_REGS];
    int                    error_cnt = 0, comparisons = 0, cycles = 0;
    always #10 clk = ~clk;
    cfgap_top cfgap_top_inst (.I_CLOCK(clk), .I_RST(rst), .I_POR(por), .I_STRAP(strap),
        .I_ADDR(addr), .I_IOR(ior), .I_IOW(iow), .I_DATA(wdata), .O_DATA(rdata),
        .O_DATA_OE(oe), .O_CONFIG_ACTIVE(act), .O_BASE_SELECT(bsel), .O_CONFIG_REGS(regs));
    cfgap_host cfgap_host_inst (.i_clk(clk), .o_addr(addr), .o_ior(ior), .o_iow(iow),
        .o_data(wdata));
    task automatic check(input logic [NUM_REGS*8-1:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
        cfgap_host_inst.io(1'h1, a, v);
        if (a[0] && act && a[9:1] == (bsel ? BASE_HIGH_ADDR[9:1] : BASE_LOW_ADDR[9:1])
            && idx <= LAST_INDEX)
            model[idx] = v;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        cfgap_host_inst.io(1'h0, a, 8'h00);
    endtask
    task automatic cmp_regs();
        for (int i = 0; i < NUM_REGS; i++)
            flat[i*8+:8] = model[i];
        check(regs, flat);
    endtask
    // oldest read note compared when the bus drive starts
    always @(posedge clk) begin
        #2;
        if (oe && !oe_q) begin
            check(exp_q.size() != 0, 1'h1);
            if (exp_q.size() != 0)
                check(rdata, exp_q.pop_front());
        end
        oe_q = oe;
        cycles++;
        if (cycles > 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    // main sequence
    initial begin
        void'($urandom(18725));
        idx = 8'h00;
        for (int i = 0; i < NUM_REGS; i++)
            model[i] = REG_DEFAULT[i];
        repeat (16) @(posedge clk);
        #1;
        por = 0;
        rst = 0;
        repeat (4) @(posedge clk);
        #2;
        check(act, 1'h0);
        cfgap_host_inst.io(1'h0, BASE_LOW_ADDR, 8'h00);
        cfgap_host_inst.io(1'h0, BASE_LOW_ADDR + 10'h001, 8'h00);
        wr(BASE_LOW_ADDR + 10'h001, 8'h5A);
        d = $urandom;
        wr(BASE_LOW_ADDR, d == ENTRY_KEY ? 8'h00 : d);
        wr(BASE_LOW_ADDR, EXIT_KEY);
        check(act, 1'h0);
        wr(BASE_LOW_ADDR, ENTRY_KEY);
        check(act, 1'h1);
        for (int k = 0; k < 7; k++) begin
            idx = k == 0 ? LAST_INDEX : (k == 6 ? 8'h30 : 8'($urandom_range(0, 47)));
            d = $urandom;
            wr(BASE_LOW_ADDR, idx);
            rd(BASE_LOW_ADDR, idx);
            wr(BASE_LOW_ADDR + 10'h001, d);
            rd(BASE_LOW_ADDR + 10'h001, idx > LAST_INDEX ? 8'h00 : d);
        end
        wr(BASE_LOW_ADDR, EXIT_KEY);
        check(act, 1'h0);
        wr(BASE_LOW_ADDR + 10'h001, 8'hC3);
        @(posedge clk);
        #1;
        strap = 1;
        repeat (4) @(posedge clk);
        #1;
        rst = 1;
        repeat (3) @(posedge clk);
        #1;
        rst = 0;
        repeat (5) @(posedge clk);
        #2;
        check(bsel, 1'h1);
        cmp_regs();
        wr(BASE_LOW_ADDR, ENTRY_KEY);
        check(act, 1'h0);
        wr(BASE_HIGH_ADDR, ENTRY_KEY);
        check(act, 1'h1);
        idx = 8'h07;
        wr(BASE_HIGH_ADDR, idx);
        wr(BASE_HIGH_ADDR + 10'h001, 8'h96);
        rd(BASE_HIGH_ADDR + 10'h001, 8'h96);
        wr(BASE_HIGH_ADDR, EXIT_KEY);
        cmp_regs();
        finish_test();
    end
endmodule
